// ==== logic/ddw_serial_port.sv ====
`timescale 1ns/1ps
module ddw_serial_port
    import ddw_pkg::*;
#(
    parameter int CMD_W  = ddw_pkg::CMD_BITS,
    parameter int CODE_W = ddw_pkg::CODE_BITS
)
(
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  serialClock,
    input  wire logic                  chipSelectN,
    input  wire logic                  serialData,
    input  wire logic                  output_transfer_strobe_n,
    input  wire logic                  standbyN,
    output logic [CODE_BITS-1:0]       output_codeA,
    output logic [CODE_BITS-1:0]       output_codeB,
    output logic                       gainSelectNA,
    output logic                       gainSelectNB,
    output logic                       refBufferedA,
    output logic                       refBufferedB,
    output logic                       outputEnableA,
    output logic                       outputEnableB
);
    import ddw_pkg::*;

    // ==========================================
    // Build checks
    if (CMD_W != CMD_BITS || CODE_W != CODE_BITS) begin : g_badWidth
        $error("Command layout is fixed at sixteen bits with twelve code bits");
    end

    // ==========================================
    // Field decoding
    function automatic logic [CODE_BITS-1:0] cmdCode(input logic [CMD_BITS-1:0] w);
        return w[CODE_BITS-1:0];
    endfunction

    function automatic logic cmdGainN(input logic [CMD_BITS-1:0] w);
        return w[GAIN_BIT];
    endfunction

    function automatic logic cmdBuffered(input logic [CMD_BITS-1:0] w);
        return w[BUF_BIT];
    endfunction

    function automatic logic cmdPowerOn(input logic [CMD_BITS-1:0] w);
        return w[PWR_BIT];
    endfunction

    function automatic logic cmdChanB(input logic [CMD_BITS-1:0] w);
        return w[CHAN_BIT];
    endfunction

    // ==========================================
    // Link domain shift register
    logic [CMD_BITS-1:0] shiftQ, shiftD;
    logic [4:0]          countQ, countD;
    logic                seenFrameQ, seenFrameD;
    logic [CMD_BITS-1:0] wordQ, wordD;
    logic                togQ, togD;
    logic                frameQ, frameD;
    logic [4:0]          countBase;
    logic                wordFull;

    // First bit of a frame restarts the count, no race with chip select rise
    assign countBase = (seenFrameQ != frameQ) ? 5'h00 : countQ;
    assign wordFull  = (countQ == CNT_FULL) && (seenFrameQ == frameQ);

    always_comb begin
        shiftD     = shiftQ;
        countD     = countQ;
        seenFrameD = seenFrameQ;
        if (!chipSelectN) begin
            seenFrameD = frameQ;
            countD     = countBase;
            if (countBase != CNT_FULL) begin
                shiftD = {shiftQ[CMD_BITS-2:0], serialData};
                countD = countBase + 5'h01;
            end
        end
    end

    always_ff @(posedge serialClock or negedge rstn) begin
        if (!rstn) begin
            shiftQ     <= CMD_RESET;
            countQ     <= 5'h00;
            seenFrameQ <= 1'b0;
        end else begin
            shiftQ     <= shiftD;
            countQ     <= countD;
            seenFrameQ <= seenFrameD;
        end
    end

    always_comb begin
        wordD  = wordQ;
        togD   = togQ;
        frameD = ~frameQ;
        if (wordFull) begin
            wordD = shiftQ;
            togD  = ~togQ;
        end
    end

    always_ff @(posedge chipSelectN or negedge rstn) begin
        if (!rstn) begin
            wordQ  <= CMD_RESET;
            togQ   <= 1'b0;
            frameQ <= 1'b0;
        end else begin
            wordQ  <= wordD;
            togQ   <= togD;
            frameQ <= frameD;
        end
    end

    // ==========================================
    // Crossing and input registers
    logic [2:0] togSyncQ, togSyncD;
    logic [1:0] ldSyncQ, ldSyncD, sbSyncQ, sbSyncD;
    logic [CMD_BITS-1:0] inAQ, inAD, inBQ, inBD;
    logic validAQ, validAD, validBQ, validBD;
    logic [CODE_BITS-1:0] codeAQ, codeAD, codeBQ, codeBD;
    logic gnAQ, gnAD, gnBQ, gnBD, bfAQ, bfAD, bfBQ, bfBD;
    logic enAQ, enAD, enBQ, enBD;
    logic newWord, xferLow, standby;
    logic pendAQ, pendAD, pendBQ, pendBD;

    assign newWord = togSyncQ[2] ^ togSyncQ[1];
    assign xferLow = ~ldSyncQ[1];
    assign standby = sbSyncQ[1];

    always_comb begin
        togSyncD = {togSyncQ[1:0], togQ};
        ldSyncD  = {ldSyncQ[0], output_transfer_strobe_n};
        sbSyncD  = {sbSyncQ[0], standbyN};
        inAD = inAQ;
        inBD = inBQ;
        validAD = validAQ;
        validBD = validBQ;
        codeAD = codeAQ;
        codeBD = codeBQ;
        gnAD = gnAQ;
        gnBD = gnBQ;
        bfAD = bfAQ;
        bfBD = bfBQ;
        pendAD = pendAQ;
        pendBD = pendBQ;
        if (xferLow && pendAQ) begin
            codeAD = cmdCode(inAQ);
            gnAD   = cmdGainN(inAQ);
            bfAD   = cmdBuffered(inAQ);
            pendAD = 1'b0;
        end
        if (xferLow && pendBQ) begin
            codeBD = cmdCode(inBQ);
            gnBD   = cmdGainN(inBQ);
            bfBD   = cmdBuffered(inBQ);
            pendBD = 1'b0;
        end
        if (newWord && !cmdChanB(wordQ)) begin
            inAD    = wordQ;
            validAD = 1'b1;
            pendAD  = 1'b1;
        end
        if (newWord && cmdChanB(wordQ)) begin
            inBD    = wordQ;
            validBD = 1'b1;
            pendBD  = 1'b1;
        end
        enAD = (xferLow && pendAQ) ? (cmdPowerOn(inAQ) & standby) : (enAQ & standby);
        enBD = (xferLow && pendBQ) ? (cmdPowerOn(inBQ) & standby) : (enBQ & standby);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            togSyncQ <= 3'h0;
            ldSyncQ  <= 2'h3;
            sbSyncQ  <= 2'h0;
            inAQ <= CMD_RESET;
            inBQ <= CMD_RESET;
            validAQ <= 1'b0;
            validBQ <= 1'b0;
            pendAQ  <= 1'b0;
            pendBQ  <= 1'b0;
            codeAQ <= 12'h000;
            codeBQ <= 12'h000;
            gnAQ <= 1'b0;
            gnBQ <= 1'b0;
            bfAQ <= 1'b0;
            bfBQ <= 1'b0;
            enAQ <= 1'b0;
            enBQ <= 1'b0;
        end else begin
            togSyncQ <= togSyncD;
            ldSyncQ  <= ldSyncD;
            sbSyncQ  <= sbSyncD;
            inAQ <= inAD;
            inBQ <= inBD;
            validAQ <= validAD;
            validBQ <= validBD;
            pendAQ  <= pendAD;
            pendBQ  <= pendBD;
            codeAQ <= codeAD;
            codeBQ <= codeBD;
            gnAQ <= gnAD;
            gnBQ <= gnBD;
            bfAQ <= bfAD;
            bfBQ <= bfBD;
            enAQ <= enAD;
            enBQ <= enBD;
        end
    end

    assign output_codeA  = codeAQ;
    assign output_codeB  = codeBQ;
    assign gainSelectNA  = gnAQ;
    assign gainSelectNB  = gnBQ;
    assign refBufferedA  = bfAQ;
    assign refBufferedB  = bfBQ;
    assign outputEnableA = enAQ;
    assign outputEnableB = enBQ;

    // ==========================================
    // Checks
    sequence seqLoadA;
        newWord && !wordQ[CHAN_BIT];
    endsequence

    sequence seqLoadB;
        newWord && wordQ[CHAN_BIT];
    endsequence

    sequence seqXferA;
        xferLow && pendAQ;
    endsequence

    sequence seqXferB;
        xferLow && pendBQ;
    endsequence

    offAtStart_a: assert property (@(posedge clock) disable iff (!rstn)
        !validAQ |-> !enAQ) else $error("Channel A enabled before write");

    standbyOff_a: assert property (@(posedge clock) disable iff (!rstn)
        !sbSyncQ[1] |=> !enAQ && !enBQ) else $error("Enabled during standby");

    xferCode_a: assert property (@(posedge clock) disable iff (!rstn)
        seqXferA |=> codeAQ == $past(inAQ[CODE_BITS-1:0]))
        else $error("Code A not transferred");

    xferCodeB_a: assert property (@(posedge clock) disable iff (!rstn)
        seqXferB |=> codeBQ == $past(inBQ[CODE_BITS-1:0]))
        else $error("Code B not transferred");

    holdCode_a: assert property (@(posedge clock) disable iff (!rstn)
        !xferLow |=> $stable(codeBQ) && $stable(codeAQ))
        else $error("Code moved without strobe");

    loadA_a: assert property (@(posedge clock) disable iff (!rstn)
        seqLoadA |=> inAQ == $past(wordQ) && $stable(inBQ))
        else $error("Channel A load wrong");

    loadB_a: assert property (@(posedge clock) disable iff (!rstn)
        seqLoadB |=> inBQ == $past(wordQ) && $stable(inAQ))
        else $error("Channel B load wrong");

    reArm_a: assert property (@(posedge clock) disable iff (!rstn)
        !(xferLow && pendAQ) && !enAQ |=> !enAQ) else $error("Channel A enabled by itself");

    pwrFollow_a: assert property (@(posedge clock) disable iff (!rstn)
        seqXferA |=> enAQ == ($past(inAQ[PWR_BIT]) && $past(standby)))
        else $error("Channel A enable wrong");

    pwrFollowB_a: assert property (@(posedge clock) disable iff (!rstn)
        seqXferB |=> enBQ == ($past(inBQ[PWR_BIT]) && $past(standby)))
        else $error("Channel B enable wrong");

    cntSat_a: assert property (@(posedge serialClock) disable iff (!rstn)
        countQ <= CNT_FULL) else $error("Bit count overflow");

    noLoad_a: assert property (@(posedge clock) disable iff (!rstn)
        !newWord |=> $stable(inAQ) && $stable(inBQ)) else $error("Spurious load");
endmodule

// ==== logic/ddw_pkg.sv ====
package ddw_pkg;
    localparam int CMD_BITS     = 16;
    localparam int CODE_BITS    = 12;
    localparam int CHAN_BIT     = 15;
    localparam int BUF_BIT      = 14;
    localparam int GAIN_BIT     = 13;
    localparam int PWR_BIT      = 12;
    localparam logic [4:0] CNT_FULL = 5'h10;
    localparam logic [15:0] CMD_RESET = 16'h0000;
endpackage

// ==== test/ddw_spi_master.sv ====
`timescale 1ns/1ps
// ====
// Write-only serial master, mode 0,0
module ddw_spi_master (
    output logic serialClock,
    output logic chipSelectN,
    output logic serialData
);
    initial begin
        serialClock = 1'b0;
        chipSelectN = 1'b1;
        serialData  = 1'b0;
    end
    task automatic send(input logic [31:0] w, input int n);
        chipSelectN = 1'b0;
        #40;
        for (int i = 0; i < n; i++) begin
            serialData = w[31-i];
            #62.5 serialClock = 1'b1;
            #62.5 serialClock = 1'b0;
        end
        #40 chipSelectN = 1'b1;
        serialData = ~serialData;
    endtask
    // Clock and data activity between frames
    task automatic noise;
        repeat (4) begin
            serialData = ~serialData;
            #62.5 serialClock = 1'b1;
            #62.5 serialClock = 1'b0;
        end
    endtask
endmodule

// ==== test/dual_dac_serial_write_port_tb.sv ====
`timescale 1ns/1ps
module dual_dac_serial_write_port_tb;
    import ddw_pkg::*;
    logic        clock = 0, rstn = 0, strobeN = 1, standbyN = 1;
    wire logic   sck, csN, sdi;
    logic [11:0] codeA, codeB;
    logic        gainA, gainB, bufA, bufB, enA, enB;
    int          failures = 0, checks_done = 0, cycles = 0;
    always #4 clock = ~clock;
    ddw_spi_master i_master (.serialClock(sck), .chipSelectN(csN), .serialData(sdi));
    ddw_serial_port i_dut (
        .clock(clock), .rstn(rstn), .serialClock(sck), .chipSelectN(csN),
        .serialData(sdi), .output_transfer_strobe_n(strobeN), .standbyN(standbyN),
        .output_codeA(codeA), .output_codeB(codeB), .gainSelectNA(gainA),
        .gainSelectNB(gainB), .refBufferedA(bufA), .refBufferedB(bufB),
        .outputEnableA(enA), .outputEnableB(enB));
    // ====
    // Helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic settle;
        repeat (12) @(posedge clock);
        #1;
    endtask
    task automatic frame(input logic [31:0] w, input int n);
        i_master.send(w, n);
        settle();
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            end_of_test();
        end
    end
    // ====
    // Scenarios
    task automatic test_staged;
        check(16'({enA, enB, gainA, gainB, codeA}), 16'h0);
        frame({16'h3ABC, 16'h0}, 16);
        check(16'({enA, codeA}), 16'h0);
        @(posedge clock) strobeN <= 1'b0;
        settle();
        check(16'(codeA), 16'hABC);
        check(16'({gainA, bufA, enA}), 16'h5);
        check(16'({enB, codeB}), 16'h0);
    endtask
    task automatic test_through;
        frame({16'hC5A5, 16'h0}, 16);
        check(16'(codeB), 16'h5A5);
        check(16'({gainB, bufB, enB}), 16'h2);
        check(16'(codeA), 16'hABC);
    endtask
    task automatic test_short;
        i_master.noise();
        frame({16'h1123, 16'h0}, 12);
        check(16'(codeA), 16'hABC);
        frame({16'h1123, 16'h0}, 15);
        check(16'(codeA), 16'hABC);
    endtask
    task automatic test_long;
        frame({16'h1FFF, 16'hA000}, 20);
        check(16'(codeA), 16'hFFF);
        check(16'({gainA, enA}), 16'h1);
    endtask
    task automatic test_standby;
        @(posedge clock) standbyN <= 1'b0;
        settle();
        check(16'(enA), 16'h0);
        @(posedge clock) standbyN <= 1'b1;
        settle();
        check(16'(enA), 16'h0);
        frame({16'h1FFF, 16'h0}, 16);
        check(16'(enA), 16'h1);
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        settle();
        test_staged();
        test_through();
        test_short();
        test_long();
        test_standby();
        end_of_test();
    end
endmodule
